// *** xram_defines.svh ***
// Constants for the data-memory access unit: SFR offsets, reset values,
// memory sizes and stretch settings.
// Assumes inclusion by bare name from the access-unit top module.
`ifndef XRAM_DEFINES_SVH
`define XRAM_DEFINES_SVH

// Special-function register addresses
`define PTR0_LOW_ADDR      8'h82
`define PTR0_HIGH_ADDR     8'h83
`define PTR1_LOW_ADDR      8'h84
`define PTR1_HIGH_ADDR     8'h85
`define POINTER_SELECT_ADDR 8'h86
`define XRAM_PAGE_ADDR     8'h92
`define STRETCH_ADDR       8'h8E

// Reset values
`define PTR_RESET          8'h00
`define SELECT_RESET       1'h0
`define PAGE_RESET         8'h00
`define STRETCH_RESET      3'h1

// Field positions
`define SELECT_BIT         0
`define STRETCH_LSB        0
`define STRETCH_MSB        2

// Memory sizes and address space split
`define IRAM_BYTES         128
`define XRAM_BYTES         2048
`define SFR_SPACE_BASE     8'h80

// Base access time in machine clocks
`define XRAM_BASE_CYCLES   3'h1

`endif

// *** xram_pkg.sv ***
// Types shared by the data-memory access unit.
// Assumes xram_defines.svh is on the include path.
package xram_pkg;

    // Kind of data-memory access requested by the core
    typedef enum logic [2:0] {
        ACC_NONE,
        ACC_IRAM_DIRECT,
        ACC_IRAM_INDIRECT,
        ACC_XRAM_POINTER,
        ACC_XRAM_PAGED,
        ACC_CODE_POINTER,
        ACC_CODE_PC
    } access_kind_t;

    // Access sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } access_state_t;

endpackage : xram_pkg

// *** byte_ram.sv ***
// Single-port byte-wide RAM with synchronous read and write.
// Assumes one clock; contents are undefined after power-up.
`timescale 1ns/100ps
`default_nettype none

module byte_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic          sys_clk_in,
    input  wire logic          we_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [7:0]    wdata_in,
    output var  logic [7:0]    rdata_out
);

    logic [7:0] mem_q [DEPTH];

    // Read-first storage: a write returns the old byte that cycle
    always_ff @(posedge sys_clk_in) begin
        if (we_in) begin
            mem_q[addr_in] <= wdata_in;
        end
        rdata_out <= mem_q[addr_in];
    end

endmodule : byte_ram
`default_nettype wire

// *** xram_address_generation.sv ***
// Data-memory access unit: internal RAM, on-chip external-data RAM,
// dual data pointers, page register, code table reads and stretch field.
// Assumes the core holds a request until done_out and keeps its SFR port
// quiet while an access is in flight.
// Notes on behaviour
// - Two on-chip memories exist: 128-byte internal and 2048-byte external.
// - No off-chip data RAM pins exist; every external access hits on chip.
// - Indirect internal moves use R0/direct moves use the address byte.
// - Direct addresses in the upper half go to the special-function space.
// - Two 16-bit data pointers, each built from separate high/low bytes.
// - The select bit picks pointer 0 when clear and pointer 1 when set.
// - Pointer-based external moves use the currently selected pointer.
// - Paged external moves use page register high and R0/low.
// - The high byte of paged moves never comes from the port two latch.
// - Code table reads fetch from accumulator plus pointer or PC.
// - Data moves never write program memory.
// - A 3-bit stretch field resets to 001; software may set 000.
// - Select register bits 7:1 read zero and the select bit resets to 0.
// - All four pointer bytes are read/write and reset to 0x00.
// - The page register sits at 0x92, read/write, resetting to 0x00.
`timescale 1ns/100ps
`default_nettype none
`include "xram_defines.svh"

module xram_address_generation
    import xram_pkg::*;
#(
    parameter int IRAM_DEPTH = `IRAM_BYTES,
    parameter int XRAM_DEPTH = `XRAM_BYTES
) (
    input  wire logic         sys_clk_in,
    input  wire logic         resetn_in,
    // Access request from the core
    input  wire logic         req_in,
    input  wire access_kind_t kind_in,
    input  wire logic         write_in,
    input  wire logic [7:0]   direct_addr_in,
    input  wire logic [7:0]   ri_in,
    input  wire logic [7:0]   acc_in,
    input  wire logic [15:0]  pc_in,
    input  wire logic [7:0]   wdata_in,
    output var  logic         done_out,
    output var  logic [7:0]   rdata_out,
    // Special-function register port
    input  wire logic         sfr_wr_in,
    input  wire logic         sfr_rd_in,
    input  wire logic [7:0]   sfr_addr_in,
    input  wire logic [7:0]   sfr_wdata_in,
    output var  logic [7:0]   sfr_rdata_out,
    output var  logic         sfr_hit_out,
    // Direct access forwarded to other special-function registers
    output var  logic         sfr_fwd_out,
    // Program-memory read port (read only)
    output var  logic         code_rd_out,
    output var  logic [15:0]  code_addr_out,
    input  wire logic [7:0]   code_data_in,
    // Pointer view for the core
    output var  logic [15:0]  active_data_pointer_out
);

    localparam int IAW = $clog2(IRAM_DEPTH);
    localparam int XAW = $clog2(XRAM_DEPTH);

    // Reset release through two flip-flops
    // Pin may fall at any time; release is aligned to the clock
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire logic rstn;
    assign rstn = rst_sync_q;

    // Register file
    logic [7:0] ptr0_low_q;
    logic [7:0] ptr0_high_q;
    logic [7:0] ptr1_low_q;
    logic [7:0] ptr1_high_q;
    logic       pointer_select_q;
    logic [7:0] xram_page_q;
    logic [2:0] xram_stretch_q;

    // SFR write decode
    // Unowned addresses decode to nothing, so their writes are dropped
    wire logic wr_p0l;
    wire logic wr_p0h;
    wire logic wr_p1l;
    wire logic wr_p1h;
    wire logic wr_sel;
    wire logic wr_page;
    wire logic wr_str;
    assign wr_p0l  = sfr_wr_in && (sfr_addr_in == `PTR0_LOW_ADDR);
    assign wr_p0h  = sfr_wr_in && (sfr_addr_in == `PTR0_HIGH_ADDR);
    assign wr_p1l  = sfr_wr_in && (sfr_addr_in == `PTR1_LOW_ADDR);
    assign wr_p1h  = sfr_wr_in && (sfr_addr_in == `PTR1_HIGH_ADDR);
    assign wr_sel  = sfr_wr_in && (sfr_addr_in == `POINTER_SELECT_ADDR);
    assign wr_page = sfr_wr_in && (sfr_addr_in == `XRAM_PAGE_ADDR);
    assign wr_str  = sfr_wr_in && (sfr_addr_in == `STRETCH_ADDR);

    always_ff @(posedge sys_clk_in or negedge rstn) begin
        if (!rstn) begin
            ptr0_low_q  <= `PTR_RESET;
            ptr0_high_q <= `PTR_RESET;
            ptr1_low_q  <= `PTR_RESET;
            ptr1_high_q <= `PTR_RESET;
        end else begin
            if (wr_p0l) ptr0_low_q  <= sfr_wdata_in;
            if (wr_p0h) ptr0_high_q <= sfr_wdata_in;
            if (wr_p1l) ptr1_low_q  <= sfr_wdata_in;
            if (wr_p1h) ptr1_high_q <= sfr_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn) begin
        if (!rstn) begin
            pointer_select_q <= `SELECT_RESET;
            xram_page_q      <= `PAGE_RESET;
            xram_stretch_q   <= `STRETCH_RESET;
        end else begin
            if (wr_sel) pointer_select_q <= sfr_wdata_in[`SELECT_BIT];
            if (wr_page) xram_page_q <= sfr_wdata_in;
            if (wr_str) begin
                xram_stretch_q <= sfr_wdata_in[`STRETCH_MSB:`STRETCH_LSB];
            end
        end
    end

    // SFR read mux; unowned addresses answer zero with no hit
    logic [7:0] sfr_rd_mux;
    logic       sfr_own;
    always_comb begin
        sfr_own    = 1'b1;
        sfr_rd_mux = 8'h00;
        case (sfr_addr_in)
            `PTR0_LOW_ADDR:       sfr_rd_mux = ptr0_low_q;
            `PTR0_HIGH_ADDR:      sfr_rd_mux = ptr0_high_q;
            `PTR1_LOW_ADDR:       sfr_rd_mux = ptr1_low_q;
            `PTR1_HIGH_ADDR:      sfr_rd_mux = ptr1_high_q;
            `POINTER_SELECT_ADDR: sfr_rd_mux = {7'h00, pointer_select_q};
            `XRAM_PAGE_ADDR:      sfr_rd_mux = xram_page_q;
            `STRETCH_ADDR:        sfr_rd_mux = {5'h00, xram_stretch_q};
            default:              sfr_own    = 1'b0;
        endcase
    end

    // Registered SFR read data
    // Zero when not reading, so an unowned read also shows zero
    always_ff @(posedge sys_clk_in or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata_out <= 8'h00;
            sfr_hit_out   <= 1'b0;
        end else begin
            sfr_rdata_out <= sfr_rd_in ? sfr_rd_mux : 8'h00;
            sfr_hit_out   <= sfr_rd_in && sfr_own;
        end
    end

    wire logic [15:0] ptr0;
    wire logic [15:0] ptr1;
    wire logic [15:0] ptr_sel;
    assign ptr0    = {ptr0_high_q, ptr0_low_q};
    assign ptr1    = {ptr1_high_q, ptr1_low_q};
    assign ptr_sel = pointer_select_q ? ptr1 : ptr0;

    // Pointer view, one cycle behind a select or byte write
    always_ff @(posedge sys_clk_in or negedge rstn) begin
        if (!rstn) begin
            active_data_pointer_out <= 16'h0000;
        end else begin
            active_data_pointer_out <= ptr_sel;
        end
    end

    // Latched request
    // Fields are held here so the core may change them after done
    access_state_t state_q;
    access_kind_t  kind_q;
    logic          write_q;
    logic [15:0]   addr_q;
    logic [7:0]    wdata_q;
    logic [2:0]    wait_q;

    // Address formation per access kind
    // Code sums wrap at 16 bits, as the program counter does
    logic [15:0] addr_d;
    always_comb begin
        case (kind_in)
            ACC_IRAM_DIRECT:   addr_d = {8'h00, direct_addr_in};
            ACC_IRAM_INDIRECT: addr_d = {8'h00, ri_in};
            ACC_XRAM_POINTER:  addr_d = ptr_sel;
            ACC_XRAM_PAGED:    addr_d = {xram_page_q, ri_in};
            ACC_CODE_POINTER:  addr_d = ptr_sel + {8'h00, acc_in};
            ACC_CODE_PC:       addr_d = pc_in + {8'h00, acc_in};
            default:           addr_d = 16'h0000;
        endcase
    end

    // direct upper half goes to SFR space
    wire logic to_sfr;
    assign to_sfr = (kind_in == ACC_IRAM_DIRECT)
                 && (direct_addr_in >= `SFR_SPACE_BASE);

    wire logic is_xram_q;
    wire logic is_code_q;
    wire logic is_iram_q;
    assign is_xram_q = (kind_q == ACC_XRAM_POINTER)
                    || (kind_q == ACC_XRAM_PAGED);
    assign is_code_q = (kind_q == ACC_CODE_POINTER)
                    || (kind_q == ACC_CODE_PC);
    assign is_iram_q = (kind_q == ACC_IRAM_DIRECT)
                    || (kind_q == ACC_IRAM_INDIRECT);

    // Incoming request decode
    wire logic req_xram;
    wire logic req_code;
    assign req_xram = (kind_in == ACC_XRAM_POINTER)
                   || (kind_in == ACC_XRAM_PAGED);
    assign req_code = (kind_in == ACC_CODE_POINTER)
                   || (kind_in == ACC_CODE_PC);

    // initial wait count; only external-data accesses stretch
    wire logic [2:0] wait_init;
    assign wait_init = req_xram ? xram_stretch_q : 3'h0;

    // Last wait edge: stores land here, read data one edge later
    wire logic last_wait;
    assign last_wait = (state_q == ST_WAIT) && (wait_q == 3'h0);

    // Access sequencer
    // One access in flight; a request still high after done is retaken
    wire logic start;
    assign start = (state_q == ST_IDLE) && req_in && !to_sfr
                && (kind_in != ACC_NONE);

    always_ff @(posedge sys_clk_in or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            kind_q  <= ACC_NONE;
            write_q <= 1'b0;
            addr_q  <= 16'h0000;
            wdata_q <= 8'h00;
            wait_q  <= 3'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        kind_q  <= kind_in;
                        write_q <= write_in;
                        addr_q  <= addr_d;
                        wdata_q <= wdata_in;
                        wait_q  <= wait_init;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wait_q == 3'h0) begin
                        state_q <= ST_DONE;
                    end else begin
                        wait_q <= wait_q - 3'h1;
                    end
                end
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // both memories on chip, no off-chip port
    // RAM contents survive reset; only registers start over
    wire logic iram_we;
    wire logic xram_we;
    wire logic [7:0] iram_q;
    wire logic [7:0] xram_q;
    assign iram_we = last_wait && write_q && is_iram_q;
    assign xram_we = last_wait && write_q && is_xram_q;

    byte_ram #(.DEPTH(IRAM_DEPTH), .AW(IAW)) iram_u (
        .sys_clk_in (sys_clk_in),
        .we_in      (iram_we),
        .addr_in    (addr_q[IAW-1:0]),
        .wdata_in   (wdata_q),
        .rdata_out  (iram_q)
    );

    byte_ram #(.DEPTH(XRAM_DEPTH), .AW(XAW)) xram_u (
        .sys_clk_in (sys_clk_in),
        .we_in      (xram_we),
        .addr_in    (addr_q[XAW-1:0]),
        .wdata_in   (wdata_q),
        .rdata_out  (xram_q)
    );

    // program memory is only ever read
    // The address holds until the next access of any kind starts
    always_ff @(posedge sys_clk_in or negedge rstn) begin
        if (!rstn) begin
            code_rd_out   <= 1'b0;
            code_addr_out <= 16'h0000;
        end else begin
            code_rd_out   <= start && req_code;
            code_addr_out <= start ? addr_d : code_addr_out;
        end
    end

    // a table read returns its byte even if write_in was set
    wire logic       take_read;
    wire logic [7:0] read_byte;
    assign take_read = (state_q == ST_DONE) && (!write_q || is_code_q);
    assign read_byte = is_xram_q ? xram_q
                     : is_code_q ? code_data_in : iram_q;

    // upper-half direct requests only pulse the forward strobe
    wire logic fwd_take;
    assign fwd_take = (state_q == ST_IDLE) && req_in && to_sfr;

    // Completion and read data
    always_ff @(posedge sys_clk_in or negedge rstn) begin
        if (!rstn) begin
            done_out    <= 1'b0;
            rdata_out   <= 8'h00;
            sfr_fwd_out <= 1'b0;
        end else begin
            done_out    <= (state_q == ST_DONE);
            sfr_fwd_out <= fwd_take;
            if (take_read) begin
                rdata_out <= read_byte;
            end
        end
    end

endmodule : xram_address_generation
`default_nettype wire

// *** code_rom_model.sv ***
// Program-memory model that answers the unit's table reads.
// Assumes code_rd_out pulses once per read and the address then holds.
`timescale 1ns/100ps
`default_nettype none
module code_rom_model (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic [15:0] addr_in,
    output var  logic [7:0]  data_out
);
    logic [1:0] hold_q = 2'h0;
    logic [7:0] junk_q = 8'h00;
    // read-only store, held a few cycles
    always_ff @(posedge clk_in) begin
        hold_q <= rd_in ? 2'h3 : hold_q - {1'b0, hold_q != 2'h0};
        junk_q <= ~junk_q;
    end
    // Outside the hold window the byte toggles every cycle
    assign data_out = (hold_q != 2'h0) ?
        (addr_in[7:0] ^ addr_in[15:8] ^ 8'h5A) : junk_q;
endmodule : code_rom_model
`default_nettype wire

// *** xram_address_generation_properties.sv ***
// Checker for the data-memory access unit, bound to its top module.
// Assumes the core holds each request until done and then drops it.
`timescale 1ns/100ps
`default_nettype none
module xram_checker
    import xram_pkg::*;
(
    input wire logic         sys_clk_in,
    input wire logic         resetn_in,
    input wire logic         req_in,
    input wire access_kind_t kind_in,
    input wire logic [7:0]   direct_addr_in,
    input wire logic [7:0]   acc_in,
    input wire logic [15:0]  pc_in,
    input wire logic         done_out,
    input wire logic         sfr_wr_in,
    input wire logic         sfr_rd_in,
    input wire logic [7:0]   sfr_addr_in,
    input wire logic [7:0]   sfr_wdata_in,
    input wire logic [7:0]   sfr_rdata_out,
    input wire logic         sfr_hit_out,
    input wire logic         sfr_fwd_out,
    input wire logic [15:0]  code_addr_out,
    input wire logic         code_rd_out,
    input wire logic [15:0]  active_data_pointer_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    logic [7:0]        b_q [4];
    logic              sel_q;
    logic [2:0]        st_q;
    wire logic [15:0]  view = sel_q ? {b_q[3], b_q[2]} : {b_q[1], b_q[0]};
    // Shadow of pointer bytes, select bit and stretch field
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            b_q   <= '{default: 8'h00};
            sel_q <= 1'b0;
            st_q  <= 3'h1;
        end else if (sfr_wr_in) begin
            if (sfr_addr_in inside {[8'h82:8'h85]})
                b_q[sfr_addr_in[1:0] + 2'h2] <= sfr_wdata_in;
            if (sfr_addr_in == 8'h86)
                sel_q <= sfr_wdata_in[0];
            if (sfr_addr_in == 8'h8E)
                st_q <= sfr_wdata_in[2:0];
        end
    end
    sequence s_take_i;
        $rose(req_in) && kind_in inside {ACC_IRAM_DIRECT, ACC_IRAM_INDIRECT}
            && !(kind_in == ACC_IRAM_DIRECT && direct_addr_in[7]);
    endsequence
    sequence s_take_x;
        $rose(req_in) && kind_in inside {ACC_XRAM_POINTER, ACC_XRAM_PAGED};
    endsequence
    sequence s_take_c;
        $rose(req_in) && kind_in inside {ACC_CODE_POINTER, ACC_CODE_PC};
    endsequence
    chk_sel_reserved:
    assert property (sfr_rd_in && sfr_addr_in == 8'h86 |=>
        sfr_hit_out && sfr_rdata_out[7:1] == 7'h00) else $error("sel bits");
    chk_page_owned:
    assert property (sfr_rd_in && sfr_addr_in == 8'h92 |=> sfr_hit_out)
        else $error("page not owned");
    chk_latch_unowned:
    assert property (sfr_rd_in && sfr_addr_in == 8'hA0 |=>
        !sfr_hit_out && sfr_rdata_out == 8'h00) else $error("latch owned");
    chk_fwd_space:
    assert property (sfr_fwd_out |-> direct_addr_in[7] && !done_out)
        else $error("bad forward");
    chk_iram_time:
    assert property (s_take_i |=> !done_out [*2] ##1 done_out)
        else $error("internal access time");
    chk_xram_fast:
    assert property (s_take_x ##0 st_q == 3'h0 |=>
        !done_out [*2] ##1 done_out) else $error("fast access time");
    chk_xram_slow:
    assert property (s_take_x ##0 st_q == 3'h1 |=>
        !done_out [*3] ##1 done_out) else $error("stretched access time");
    chk_code_sum:
    assert property ($rose(req_in) && kind_in == ACC_CODE_PC |->
        ##2 code_addr_out == pc_in + {8'h00, acc_in}) else $error("code addr");
    chk_code_strobe:
    assert property (s_take_c |=> code_rd_out ##1 !code_rd_out)
        else $error("code strobe");
    chk_ptr_view:
    assert property (active_data_pointer_out == $past(view))
        else $error("pointer view");
endmodule : xram_checker
bind xram_address_generation xram_checker xram_checker_i (.*);
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the data-memory access unit.
// Assumes the unit leaves reset two edges after resetn_in rises.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import xram_pkg::*;
;
    logic         sys_clk_in = 1'b0, resetn_in = 1'b0, req_in = 1'b0;
    logic         write_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
    access_kind_t kind_in = ACC_NONE;
    logic [7:0]   direct_addr_in = 8'h00, ri_in = 8'h00, acc_in = 8'h00;
    logic [7:0]   wdata_in = 8'h00, sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00;
    logic [15:0]  pc_in = 16'h0000, code_addr_out, active_data_pointer_out;
    logic [7:0]   rdata_out, sfr_rdata_out, code_data_in, got;
    logic         done_out, sfr_hit_out, sfr_fwd_out, code_rd_out;
    int           miscompares = 0, checked = 0, n = 0;
    logic [23:0]  rows [8] = '{24'h82A5A5, 24'h833C3C, 24'h845A5A, 24'h85C3C3,
                             24'h86FF01, 24'h927E7E, 24'h8E0000, 24'hA0FF00};
    xram_address_generation xram_address_generation_i (.*);
    code_rom_model code_rom_model_i (.clk_in(sys_clk_in), .rd_in(code_rd_out),
        .addr_in(code_addr_out), .data_out(code_data_in));
    // 125 MHz clock
    always #4 sys_clk_in = ~sys_clk_in;
    function automatic logic [7:0] rom(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : rom
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    // One register cycle; read data lands one edge later
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in) #1;
        sfr_wr_in = w;
        sfr_rd_in = !w;
        sfr_addr_in = a;
        sfr_wdata_in = d;
        @(posedge sys_clk_in) #1;
        got = sfr_rdata_out;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
    endtask : sfr
    // Request held until done or forward, n counts edges taken
    task automatic go(input access_kind_t k, input logic w,
                      input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in) #1;
        req_in = 1'b1;
        kind_in = k;
        write_in = w;
        direct_addr_in = a;
        ri_in = a;
        wdata_in = d;
        n = 0;
        do begin
            @(posedge sys_clk_in) #1;
            n++;
        end while (!done_out && !sfr_fwd_out && n < 12);
        got = rdata_out;
        req_in = 1'b0;
    endtask : go
    // Reads every row's register and expects its reset value
    task automatic reset_rows;
        foreach (rows[i]) begin
            sfr(1'b0, rows[i][23:16], 8'h00);
            chk(got, {7'h00, rows[i][23:16] == 8'h8E});
        end
    endtask : reset_rows
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // Main sequence: reset, register rows, then access cases
    initial begin
        repeat (5) @(posedge sys_clk_in);
        #1 resetn_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reset_rows();
        $display("reset values done");
        go(ACC_XRAM_POINTER, 1'b1, 8'h00, 8'h77);
        chk(n, 4);
        foreach (rows[i]) begin
            sfr(1'b1, rows[i][23:16], rows[i][15:8]);
            sfr(1'b0, rows[i][23:16], 8'h00);
            chk(got, rows[i][7:0]);
            chk(sfr_hit_out, rows[i][23:16] != 8'hA0);
        end
        chk(active_data_pointer_out, 16'hC35A);
        $display("register table done");
        go(ACC_XRAM_POINTER, 1'b1, 8'h00, 8'h11);
        chk(n, 3);
        sfr(1'b1, 8'h86, 8'h00);
        go(ACC_XRAM_POINTER, 1'b1, 8'h00, 8'h22);
        chk(active_data_pointer_out, 16'h3CA5);
        sfr(1'b1, 8'h92, 8'h03);
        go(ACC_XRAM_PAGED, 1'b0, 8'h5A, 8'h00);
        chk(got, 8'h11);
        go(ACC_XRAM_POINTER, 1'b0, 8'h00, 8'h00);
        chk(got, 8'h22);
        $display("external data done");
        go(ACC_IRAM_DIRECT, 1'b1, 8'h10, 8'h33);
        go(ACC_IRAM_DIRECT, 1'b1, 8'h90, 8'h44);
        chk({done_out, sfr_fwd_out}, 2'b01);
        go(ACC_IRAM_INDIRECT, 1'b0, 8'h10, 8'h00);
        chk(got, 8'h33);
        chk(n, 3);
        $display("internal data done");
        acc_in = 8'h20;
        pc_in = 16'hFFF0;
        go(ACC_CODE_PC, 1'b1, 8'h00, 8'h00);
        chk(got, rom(16'h0010));
        acc_in = 8'h5B;
        go(ACC_CODE_POINTER, 1'b0, 8'h00, 8'h00);
        chk(got, rom(16'h3D00));
        $display("code reads done");
        // Mid-run reset: registers start over, RAM keeps its bytes
        @(posedge sys_clk_in) #1;
        resetn_in = 1'b0;
        @(posedge sys_clk_in) #1;
        chk(active_data_pointer_out, 16'h0000);
        resetn_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reset_rows();
        go(ACC_XRAM_POINTER, 1'b0, 8'h00, 8'h00);
        chk(n, 4);
        chk(got, 8'h77);
        $display("mid-run reset done");
        report_and_stop();
    end
    // Watchdog: the tests need about 125 cycles
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
